// [logic/fcs_defines.vh]
/*
 Constants of the flash command sequencer host: register map, status bit
 positions, operation codes, flash command bytes and timing counts.
 Assumes a 25 MHz aclk and a byte-wide flash with a 17-bit address.
*/
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Own register map, byte offsets
`define FCS_REG_CTRL     8'h00
`define FCS_REG_ADDR     8'h04
`define FCS_REG_WDATA    8'h08
`define FCS_REG_STATUS   8'h0c
`define FCS_REG_RDATA    8'h10

// Status bit positions
`define FCS_ST_BUSY      0
`define FCS_ST_ASEL      1
`define FCS_ST_WIN       2
`define FCS_ST_ERR       3
`define FCS_ST_TLIM      4
`define FCS_ST_EWIN      5

// Flag positions inside a byte read back from the flash
`define FCS_DQ_TLIM      5
`define FCS_DQ_EWIN      3

// Operation codes written to CTRL[2:0]
`define FCS_OP_RESET     3'h0
`define FCS_OP_READ      3'h1
`define FCS_OP_ASEL      3'h2
`define FCS_OP_PROG      3'h3
`define FCS_OP_CHIP      3'h4
`define FCS_OP_SECT      3'h5
`define FCS_OP_ADDSECT   3'h6
`define FCS_OP_ASELRD    3'h7

// Flash command words
`define FCS_UNLOCK_A1    17'h00555
`define FCS_UNLOCK_A2    17'h002aa
`define FCS_UNLOCK_D1    8'haa
`define FCS_UNLOCK_D2    8'h55
`define FCS_CMD_RESET    8'hf0
`define FCS_CMD_ASEL     8'h90
`define FCS_CMD_PROG     8'ha0
`define FCS_CMD_ERASE    8'h80
`define FCS_CMD_CHIP     8'h10
`define FCS_CMD_SECT     8'h30

// Timing
`define FCS_CLK_PERIOD_NS 40
`define FCS_CLK_MHZ       25
`define FCS_T_WP_NS       80
`define FCS_T_WP_CYC      ((`FCS_T_WP_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_T_ACC_NS      120
`define FCS_T_ACC_CYC     ((`FCS_T_ACC_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_WIN_US        50
`define FCS_WIN_CYC       (`FCS_WIN_US * `FCS_CLK_MHZ)

`endif

// [logic/fcs_bus_cycle.v]
/*
 One flash bus cycle, write or read, on the chip select, write strobe and
 output enable pins. Assumes a start pulse only while idle; the data input
 pins are asynchronous and pass two flip-flops.
*/
`default_nettype none
`include "fcs_defines.vh"

module fcs_bus_cycle (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        start,
	input  wire        wr,
	input  wire [16:0] addr,
	input  wire [7:0]  wdata,
	output reg         done,
	output reg  [7:0]  rdata,
	output reg  [16:0] flash_addr,
	output reg         flash_ce_n,
	output reg         flash_we_n,
	output reg         flash_oe_n,
	output reg  [7:0]  flash_dq_out,
	output reg         flash_dq_oe,
	input  wire [7:0]  flash_dq_in
);

localparam [2:0] C_IDLE  = 3'h0;
localparam [2:0] C_SETUP = 3'h1;
localparam [2:0] C_PULSE = 3'h2;
localparam [2:0] C_HOLD  = 3'h3;
localparam [2:0] C_RWAIT = 3'h4;
localparam integer WP_LAST_I = `FCS_T_WP_CYC - 1;
// Two extra cycles cover the input synchroniser
localparam integer RD_LAST_I = `FCS_T_ACC_CYC + 2;
localparam [3:0]   WP_LAST   = WP_LAST_I[3:0];
localparam [3:0]   RD_LAST   = RD_LAST_I[3:0];

reg [2:0] state;
reg [3:0] cnt;
reg [7:0] dq_s1;
reg [7:0] dq_s2;

////////////////////////////////////////////////////////////////////////
always @(posedge aclk) begin
	dq_s1 <= flash_dq_in;
	dq_s2 <= dq_s1;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		state        <= C_IDLE;
		cnt          <= 4'h0;
		done         <= 1'b0;
		rdata        <= 8'h00;
		flash_addr   <= 17'h00000;
		flash_ce_n   <= 1'b1;
		flash_we_n   <= 1'b1;
		flash_oe_n   <= 1'b1;
		flash_dq_out <= 8'h00;
		flash_dq_oe  <= 1'b0;
	end else begin
		done <= 1'b0;
		case (state)
		C_IDLE: begin
			if (start) begin
				flash_addr <= addr;
				flash_ce_n <= 1'b0;
				if (wr) begin
					flash_dq_out <= wdata;
					flash_dq_oe  <= 1'b1;
					state        <= C_SETUP;
				end else begin
					flash_oe_n <= 1'b0;
					cnt        <= RD_LAST;
					state      <= C_RWAIT;
				end
			end
		end
		C_SETUP: begin
			// Strobe falls after select, so the address latches here
			flash_we_n <= 1'b0;
			cnt        <= WP_LAST;
			state      <= C_PULSE;
		end
		C_PULSE: begin
			if (cnt == 4'h0) begin
				// Data still driven across the rising strobe
				flash_we_n <= 1'b1;
				state      <= C_HOLD;
			end else begin
				cnt <= cnt - 4'h1;
			end
		end
		C_HOLD: begin
			flash_ce_n  <= 1'b1;
			flash_dq_oe <= 1'b0;
			done        <= 1'b1;
			state       <= C_IDLE;
		end
		C_RWAIT: begin
			if (cnt == 4'h0) begin
				rdata      <= dq_s2;
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				done       <= 1'b1;
				state      <= C_IDLE;
			end else begin
				cnt <= cnt - 4'h1;
			end
		end
		default: begin
			state <= C_IDLE;
		end
		endcase
	end
end

endmodule
`default_nettype wire

// [logic/fcs_flash_host.v]
/*
 Host controller for a byte-wide parallel flash: software orders command
 sequences through AXI4-Lite registers, the block plays them on the pins.
 Assumes a single aclk; the flash data pins are resolved by the bench.
*/
`default_nettype none
`include "fcs_defines.vh"

module fcs_flash_host #(
	parameter WIN_CYC = `FCS_WIN_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire [16:0] flash_addr,
	output wire        flash_ce_n,
	output wire        flash_we_n,
	output wire        flash_oe_n,
	output wire [7:0]  flash_dq_out,
	output wire        flash_dq_oe,
	input  wire [7:0]  flash_dq_in
);

localparam [1:0]  S_IDLE  = 2'h0;
localparam [1:0]  S_ISSUE = 2'h1;
localparam [1:0]  S_WAIT  = 2'h2;
localparam [1:0]  RESP_OK = 2'b00;
localparam [1:0]  RESP_SE = 2'b10;
localparam integer WIN_LAST_I = WIN_CYC - 1;
localparam [10:0] WIN_LAST = WIN_LAST_I[10:0];

reg  [7:0]  aw_addr;
reg         aw_got;
reg  [31:0] w_data;
reg         w_got;
reg  [16:0] addr_reg;
reg  [7:0]  wdata_reg;
reg  [7:0]  rdata_reg;
reg         launch;
reg  [2:0]  launch_op;
reg  [1:0]  state;
reg  [2:0]  op;
reg  [2:0]  step;
reg         busy;
reg         autosel;
reg         win_open;
reg  [10:0] win_cnt;
reg         err;
reg         cyc_start;
reg         cyc_wr;
reg  [16:0] cyc_addr;
reg  [7:0]  cyc_wdata;
wire        cyc_done;
wire [7:0]  cyc_rdata;
wire [24:0] seq_word;
wire [2:0]  seq_last;
wire        op_is_read;
wire        allowed;

////////////////////////////////////////////////////////////////////////
// Sequence tables

// Length of each sequence minus one
function [2:0] seq_len;
	input [2:0] o;
	begin
		case (o)
		`FCS_OP_ASEL: seq_len = 3'h2;
		`FCS_OP_PROG: seq_len = 3'h3;
		`FCS_OP_CHIP: seq_len = 3'h5;
		`FCS_OP_SECT: seq_len = 3'h5;
		default:      seq_len = 3'h0;
		endcase
	end
endfunction

// Address and data of one step, {addr, data}
function [24:0] seq_step;
	input [2:0]  o;
	input [2:0]  i;
	input [16:0] a;
	input [7:0]  d;
	reg   [16:0] sa;
	begin
		sa = {a[16:14], 14'h0000};
		case (o)
		`FCS_OP_RESET:   seq_step = {a, `FCS_CMD_RESET};
		`FCS_OP_ADDSECT: seq_step = {sa, `FCS_CMD_SECT};
		`FCS_OP_READ:    seq_step = {a, 8'h00};
		`FCS_OP_ASELRD:  seq_step = {a, 8'h00};
		default: begin
			// Unlock pattern and selector byte
			case (i)
			3'h0: seq_step = {`FCS_UNLOCK_A1, `FCS_UNLOCK_D1};
			3'h1: seq_step = {`FCS_UNLOCK_A2, `FCS_UNLOCK_D2};
			3'h2: seq_step = {`FCS_UNLOCK_A1, (o == `FCS_OP_ASEL) ? `FCS_CMD_ASEL :
				(o == `FCS_OP_PROG) ? `FCS_CMD_PROG : `FCS_CMD_ERASE};
			3'h3: seq_step = (o == `FCS_OP_PROG) ? {a, d} : {`FCS_UNLOCK_A1, `FCS_UNLOCK_D1};
			3'h4: seq_step = {`FCS_UNLOCK_A2, `FCS_UNLOCK_D2};
			default: seq_step = (o == `FCS_OP_CHIP) ? {`FCS_UNLOCK_A1, `FCS_CMD_CHIP}
				: {sa, `FCS_CMD_SECT};
			endcase
		end
		endcase
	end
endfunction

assign seq_word   = seq_step(op, step, addr_reg, wdata_reg);
assign seq_last   = seq_len(op);
assign op_is_read = (op == `FCS_OP_READ) || (op == `FCS_OP_ASELRD);

// Autoselect is left only by reset; adds only while the window runs
assign allowed = autosel ? ((launch_op == `FCS_OP_RESET) || (launch_op == `FCS_OP_ASELRD))
	: ((launch_op != `FCS_OP_ASELRD) && ((launch_op != `FCS_OP_ADDSECT) || win_open));

////////////////////////////////////////////////////////////////////////
// AXI4-Lite write side and writable registers

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready  <= 1'b1;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= RESP_OK;
		aw_got        <= 1'b0;
		w_got         <= 1'b0;
		aw_addr       <= 8'h00;
		w_data        <= 32'h00000000;
		addr_reg      <= 17'h00000;
		wdata_reg     <= 8'h00;
		launch        <= 1'b0;
		launch_op     <= `FCS_OP_RESET;
	end else begin
		launch <= 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr       <= s_axi_awaddr;
			aw_got        <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data       <= s_axi_wdata;
			w_got        <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (aw_got && w_got && !s_axi_bvalid) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= RESP_OK;
			case (aw_addr)
			`FCS_REG_CTRL: begin
				// Orders arriving while busy are dropped without setting the error flag
				launch    <= 1'b1;
				launch_op <= w_data[2:0];
			end
			`FCS_REG_ADDR:  addr_reg  <= w_data[16:0];
			`FCS_REG_WDATA: wdata_reg <= w_data[7:0];
			`FCS_REG_STATUS: begin
			end
			`FCS_REG_RDATA: begin
			end
			default: s_axi_bresp <= RESP_SE;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid  <= 1'b0;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite read side

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h00000000;
		s_axi_rresp   <= RESP_OK;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OK;
			case (s_axi_araddr)
			`FCS_REG_CTRL:   s_axi_rdata <= {29'h00000000, op};
			`FCS_REG_ADDR:   s_axi_rdata <= {15'h0000, addr_reg};
			`FCS_REG_WDATA:  s_axi_rdata <= {24'h000000, wdata_reg};
			`FCS_REG_STATUS: s_axi_rdata <= {26'h0000000, rdata_reg[`FCS_DQ_EWIN],
				rdata_reg[`FCS_DQ_TLIM], err, win_open, autosel, busy};
			`FCS_REG_RDATA:  s_axi_rdata <= {24'h000000, rdata_reg};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= RESP_SE;
			end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Command sequencer

always @(posedge aclk) begin
	if (!aresetn) begin
		state     <= S_IDLE;
		op        <= `FCS_OP_RESET;
		step      <= 3'h0;
		busy      <= 1'b0;
		autosel   <= 1'b0;
		win_open  <= 1'b0;
		win_cnt   <= 11'h000;
		err       <= 1'b0;
		rdata_reg <= 8'h00;
		cyc_start <= 1'b0;
		cyc_wr    <= 1'b0;
		cyc_addr  <= 17'h00000;
		cyc_wdata <= 8'h00;
	end else begin
		cyc_start <= 1'b0;
		// Host-side copy of the acceptance window
		if (win_open) begin
			if (win_cnt == 11'h000)
				win_open <= 1'b0;
			else
				win_cnt <= win_cnt - 11'h001;
		end
		case (state)
		S_IDLE: begin
			if (launch) begin
				if (allowed) begin
					op    <= launch_op;
					step  <= 3'h0;
					busy  <= 1'b1;
					err   <= 1'b0;
					state <= S_ISSUE;
					// Any other write cancels the pending erase
					if (launch_op != `FCS_OP_ADDSECT && launch_op != `FCS_OP_READ)
						win_open <= 1'b0;
				end else begin
					err <= 1'b1;
				end
			end
		end
		S_ISSUE: begin
			cyc_start <= 1'b1;
			cyc_wr    <= !op_is_read;
			cyc_addr  <= seq_word[24:8];
			cyc_wdata <= seq_word[7:0];
			state     <= S_WAIT;
		end
		S_WAIT: begin
			if (cyc_done) begin
				if (op_is_read)
					rdata_reg <= cyc_rdata;
				if (step == seq_last) begin
					busy  <= 1'b0;
					state <= S_IDLE;
					if (op == `FCS_OP_ASEL)
						autosel <= 1'b1;
					if (op == `FCS_OP_RESET)
						autosel <= 1'b0;
					// Window counted from the last strobe rise
					if (op == `FCS_OP_SECT || op == `FCS_OP_ADDSECT) begin
						win_open <= 1'b1;
						win_cnt  <= WIN_LAST;
					end
				end else begin
					step  <= step + 3'h1;
					state <= S_ISSUE;
				end
			end
		end
		default: begin
			state <= S_IDLE;
		end
		endcase
	end
end

fcs_bus_cycle u_cycle (
	.aclk         (aclk),
	.aresetn      (aresetn),
	.start        (cyc_start),
	.wr           (cyc_wr),
	.addr         (cyc_addr),
	.wdata        (cyc_wdata),
	.done         (cyc_done),
	.rdata        (cyc_rdata),
	.flash_addr   (flash_addr),
	.flash_ce_n   (flash_ce_n),
	.flash_we_n   (flash_we_n),
	.flash_oe_n   (flash_oe_n),
	.flash_dq_out (flash_dq_out),
	.flash_dq_oe  (flash_dq_oe),
	.flash_dq_in  (flash_dq_in)
);

endmodule
`default_nettype wire

// [verification/fcs_flash_host_properties.sv]
/* Checker on the flash host ports.
 Bound into fcs_flash_host from the bench top. */
`default_nettype none
module fcs_flash_host_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [16:0] flash_addr,
	input wire logic        flash_ce_n,
	input wire logic        flash_we_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_dq_oe,
	input wire logic [7:0]  flash_dq_out,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////
	sequence s_pulse;
		!flash_we_n ##1 !flash_we_n ##1 flash_we_n;
	endsequence
	sequence s_hold;
		!flash_ce_n ##1 flash_ce_n;
	endsequence
	a_we_cycle: assert property ($fell(flash_we_n) |-> s_pulse ##0 s_hold) else $error("bad strobe");
	a_we_qual: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe) else $error("bad write");
	a_we_stable: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("moved");
	a_rd_qual: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe && flash_we_n) else $error("bad read");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
endmodule
`default_nettype wire

// [verification/fcs_flash_model.sv]
/* Behavioural byte-wide flash: decoder, array, timers.
 Assumes the bench resolves the shared data pins. */
`default_nettype none
module fcs_flash_model #(
	parameter       WIN_NS = 50000,
	parameter       OP_NS  = 5000,
	parameter [7:0] MAKER  = 8'h11, // Arbitrary value
	parameter [7:0] DEV_ID = 8'h22, // Arbitrary value
	parameter [7:0] PROT   = 8'h00
) (
	input  wire logic [16:0] addr,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [7:0]  dq_i,
	output wire logic [7:0]  dq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:131071];
	logic [16:0] la, pa;
	logic [2:0]  step;
	logic [7:0]  sq, rd;
	logic        asel, busy, ers, win, tlim, tog, wr_on;
	realtime     t_end;
	int          k;
	initial begin
		for (k = 0; k < 131072; k++) mem[k] = 8'hff;
		{step, sq, asel, busy, ers, win, tlim, tog, wr_on, pa} = '0;
	end
	task automatic wipe(input logic [7:0] v);
		for (k = 0; k < 131072; k++) if (sq[k[16:14]]) mem[k] = v;
	endtask
	task automatic go_erase();
		wipe(8'h00);
		{busy, ers, step} = 5'b11000;
		t_end = $realtime + OP_NS;
	endtask
	////////////////
	task automatic cmd(input logic [16:0] a, input logic [7:0] d);
		if (busy) begin
			if (tlim && d == 8'hf0) {busy, tlim, ers} = '0;
		end else if (win && d == 8'h30) begin
			sq[a[16:14]] = 1'b1;
			t_end = $realtime + WIN_NS;
		end else if (win || d == 8'hf0) {win, sq, asel, step} = '0;
		else if (step == 0 || step == 4) step = (d == 8'haa && a == 17'h555) ? step + 3'd1 : 3'd0;
		else if (step == 1 || step == 5) step = (d == 8'h55 && a == 17'h2aa) ? step + 3'd1 : 3'd0;
		else if (step == 2 && a == 17'h555 && d == 8'h90) {asel, step} = 4'b1000;
		else if (step == 2 && a == 17'h555 && d == 8'ha0) step = 3'd3;
		else if (step == 2 && a == 17'h555 && d == 8'h80) step = 3'd4;
		else if (step == 3) begin
			pa = a;
			tlim = |(d & ~mem[a]);
			mem[a] = mem[a] & d;
			{busy, step} = 4'b1000;
			t_end = $realtime + OP_NS;
		end else if (step == 6 && a == 17'h555 && d == 8'h10) begin
			sq = 8'hff;
			go_erase();
		end else if (step == 6 && d == 8'h30) begin
			sq[a[16:14]] = 1'b1;
			{win, step} = 4'b1000;
			t_end = $realtime + WIN_NS;
		end else step = 3'd0;
	endtask
	// Address at the later fall, data at the earlier rise
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) begin
		la = addr;
		wr_on = 1'b1;
	end
	always @(posedge we_n or posedge ce_n) if (wr_on) begin
		wr_on = 1'b0;
		cmd(la, dq_i);
	end
	// Coarse poll of the timers, finer than any host read
	always #20 begin
		if (win && $realtime >= t_end) begin
			win = 1'b0;
			go_erase();
		end else if (busy && !tlim && $realtime >= t_end) begin
			if (ers) wipe(8'hff);
			{busy, ers, sq} = '0;
		end
	end
	always @(negedge oe_n) if (busy || win) tog = ~tog;
	assign rd = (busy || win) ? {~mem[pa][7], tog, tlim, 1'b0, ers, 3'b000}
		: !asel ? mem[addr]
		: addr[1:0] == 2'd0 ? MAKER : addr[1:0] == 2'd1 ? DEV_ID
		: addr[1:0] == 2'd2 ? {7'd0, PROT[addr[16:14]]} : 8'h00;
	// Undriven pins show the inverse, never a stale match
	assign dq_o = (!ce_n && !oe_n) ? rd : ~rd;
endmodule
`default_nettype wire

// [verification/fcs_flash_host_tb.sv]
/* Self-checking bench of the flash host against the flash model.
 Assumes the design files and fcs_defines.vh on the include path. */
`default_nettype none
`include "fcs_defines.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module fcs_flash_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [7:0] MAKER  = 8'h5a; // Arbitrary value
	localparam [7:0] DEV_ID = 8'hc3; // Arbitrary value
	localparam [7:0] PROT   = 8'h24;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0, dq_in, mdq, dq_out;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, ce_n, we_n, oe_n, dq_oe;
	logic [16:0] fa;
	int          err_count = 0, check_count = 0;
	always #20 aclk = ~aclk;
	assign dq_in = dq_oe ? dq_out : mdq;
	fcs_flash_host #(.WIN_CYC(100)) fcs_flash_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(fa),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in));
	fcs_flash_model #(.WIN_NS(4000), .MAKER(MAKER), .DEV_ID(DEV_ID), .PROT(PROT)) fcs_flash_model_i (.addr(fa),
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_i(dq_in), .dq_o(mdq));
	////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		`CHK("bvalid", 1'b1, bvalid)
		`CHK("bresp", er, bresp)
		if (n == 50) close_out();
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		r = rdata;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rresp", er, rresp)
		if (n == 50) close_out();
	endtask
	task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d);
		logic [31:0] s;
		int n;
		axw(`FCS_REG_ADDR, {15'd0, a}, 2'b00);
		axw(`FCS_REG_WDATA, {24'd0, d}, 2'b00);
		axw(`FCS_REG_CTRL, {29'd0, c}, 2'b00);
		repeat (3) @(posedge aclk);
		for (n = 0; n < 300; n++) begin
			axr(`FCS_REG_STATUS, 2'b00, s);
			if (s[`FCS_ST_BUSY] === 1'b0) break;
		end
		`CHK("idle", 1'b0, s[`FCS_ST_BUSY])
		if (n == 300) close_out();
	endtask
	task automatic fread(input logic [16:0] a, output logic [7:0] v);
		logic [31:0] r;
		op(`FCS_OP_READ, a, 8'h00);
		axr(`FCS_REG_RDATA, 2'b00, r);
		v = r[7:0];
	endtask
	// Two equal reads in a row: toggling has stopped
	task automatic settle(input logic [16:0] a, output logic [7:0] v);
		logic [7:0] p;
		int n;
		fread(a, p);
		for (n = 0; n < 200; n++) begin
			fread(a, v);
			if (v === p) break;
			p = v;
		end
		// A value that never settles is a hang, not a pass
		if (n == 200) begin
			err_count++;
			close_out();
		end
	endtask
	task automatic st_bit(input int b, input logic e);
		logic [31:0] s;
		axr(`FCS_REG_STATUS, 2'b00, s);
		`CHK("status", e, s[b])
	endtask
	function automatic logic [7:0] id_exp(input logic [16:0] a);
		case (a[1:0])
			2'd0: return MAKER;
			2'd1: return DEV_ID;
			2'd2: return {7'd0, PROT[a[16:14]]};
			default: return 8'h00;
		endcase
	endfunction
	////////////////
	initial begin
		logic [31:0] s;
		logic [16:0] a, ka;
		logic [7:0]  d, v;
		int          i;
		void'($urandom(32'h3850));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`FCS_REG_STATUS, 2'b00, s);
		`CHK("status0", 32'h0, s)
		axr(8'h40, 2'b10, s);
		axw(8'h40, 32'h0, 2'b10);
		fread({2'b10, 15'($urandom)}, v);
		`CHK("blank", 8'hff, v)
		for (i = 0; i < 4; i++) begin
			a = {3'd1, i[1:0], 12'($urandom)};
			d = 8'($urandom) & 8'hfe;
			op(`FCS_OP_PROG, a, d);
			settle(a, v);
			`CHK("prog", d, v)
		end
		// Setting a cleared bit back stalls until reset
		op(`FCS_OP_PROG, a, ~d);
		fread(a, v);
		st_bit(`FCS_ST_TLIM, 1'b1);
		op(`FCS_OP_RESET, 17'($urandom), 8'h00);
		fread(a, v);
		`CHK("cleared", 8'h00, v)
		op(`FCS_OP_ASEL, 17'h0, 8'h00);
		st_bit(`FCS_ST_ASEL, 1'b1);
		for (i = 0; i < 9; i++) begin
			ka = {i[2:0], 12'($urandom), 2'(i % 3)};
			op(`FCS_OP_ASELRD, ka, 8'h00);
			axr(`FCS_REG_RDATA, 2'b00, s);
			`CHK("ident", {24'd0, id_exp(ka)}, s)
		end
		op(`FCS_OP_PROG, a, 8'h00);
		st_bit(`FCS_ST_ERR, 1'b1);
		op(`FCS_OP_RESET, 17'($urandom), 8'h00);
		fread(a, v);
		`CHK("array", 8'h00, v)
		for (i = 6; i < 8; i++) begin
			op(3'(i), 17'h0, 8'h00);
			st_bit(`FCS_ST_ERR, 1'b1);
		end
		ka = {3'd6, 14'($urandom)};
		op(`FCS_OP_PROG, ka, 8'h3c);
		settle(ka, v);
		op(`FCS_OP_PROG, 17'h14000, 8'h00);
		settle(17'h14000, v);
		op(`FCS_OP_SECT, {3'd1, 14'h0}, 8'h00);
		op(`FCS_OP_ADDSECT, 17'h14000, 8'h00);
		st_bit(`FCS_ST_WIN, 1'b1);
		settle(a, v);
		`CHK("sect1", 8'hff, v)
		fread(17'h14000, v);
		`CHK("sect5", 8'hff, v)
		fread(ka, v);
		`CHK("sect6", 8'h3c, v)
		// Reset in the window must cancel the erase
		op(`FCS_OP_SECT, {3'd6, 14'h0}, 8'h00);
		// A read is no command, so the window stays open
		fread(ka, v);
		st_bit(`FCS_ST_EWIN, 1'b0);
		op(`FCS_OP_RESET, 17'($urandom), 8'h00);
		settle(ka, v);
		`CHK("kept", 8'h3c, v)
		op(`FCS_OP_CHIP, 17'h0, 8'h00);
		fread(ka, v);
		st_bit(`FCS_ST_EWIN, 1'b1);
		settle(ka, v);
		`CHK("chip", 8'hff, v)
		close_out();
	end
	initial begin
		#3000000;
		err_count++;
		close_out();
	end
endmodule
bind fcs_flash_host fcs_flash_host_properties fcs_flash_host_properties_i (.aclk(aclk), .aresetn(aresetn),
	.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
	.flash_dq_oe(flash_dq_oe), .flash_dq_out(flash_dq_out), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
